// ==== core/txfr_pkg.sv ====
// constants shared by the transmit frame readout block
// assumes a word-wide fifo store and an apb register bus with 32-bit data
package txfr_pkg;

    // ========================================================
    // fifo geometry
    localparam int          TXFR_PTR_W        = 12;
    localparam int          TXFR_HDR_WORDS    = 3;   // length word plus two command words
    localparam int          TXFR_NW_W         = 18;

    // ========================================================
    // first command word fields
    localparam int          TXFR_A_IGMP       = 29;
    localparam int          TXFR_A_ICMP       = 28;
    localparam int          TXFR_A_LSO        = 27;
    localparam int          TXFR_A_IPCS       = 26;
    localparam int          TXFR_A_L4CS       = 25;
    localparam int          TXFR_A_TAGINS     = 24;
    localparam int          TXFR_A_TAGREP     = 23;
    localparam int          TXFR_A_FCSPAD     = 22;

    // ========================================================
    // check limits
    localparam logic [13:0] TXFR_MSS_MIN      = 14'h0008;
    localparam logic [9:0]  TXFR_HDR_MAX      = 10'h100;
    localparam logic [15:0] TXFR_LEN_LO_MAX   = 16'h2ff7;
    localparam logic [19:0] TXFR_LEN_MIN_RAW  = 20'h00020;
    localparam logic [15:0] TXFR_TAG_TYPE_DEF = 16'h8100;
    localparam logic [TXFR_NW_W-1:0] TXFR_TAG_WORD_IDX = 18'h00003;

    // ========================================================
    // register map, byte addresses
    localparam logic [7:0]  TXFR_OFS_ERRSTAT  = 8'h00;
    localparam logic [7:0]  TXFR_OFS_CONFIG   = 8'h04;
    localparam logic [7:0]  TXFR_OFS_ALT_TYPE = 8'h08;
    localparam logic [7:0]  TXFR_OFS_STATE    = 8'h0c;
    localparam int          TXFR_STS_ERR      = 0;
    localparam int          TXFR_CFG_STALLDIS = 0;
    localparam int          TXFR_ALT_EN       = 16;
    localparam logic        TXFR_RST_STALLDIS = 1'b0;
    localparam logic [15:0] TXFR_RST_ALT_TYPE = 16'h8100;

    typedef enum logic [2:0] {
        TXFR_IDLE,
        TXFR_CMDA,
        TXFR_CMDB,
        TXFR_DATA,
        TXFR_DONE,
        TXFR_HALT
    } txfr_st_t;

endpackage

// ==== core/txfr_readout.sv ====
// transmit fifo readout: strips header words, checks commands, handles tags,
// streams the frame to the mac and obeys rewind and release requests.
// assumes an asynchronous-read fifo store on the same clock and a mac that
// takes a word when mac_valid_o and mac_ready_i are both high.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps

module txfr_readout
    import txfr_pkg::*;
(
    // clock and reset
    input  wire logic                  mclk_i,
    input  wire logic                  arst_n_i,
    // apb slave
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [7:0]            paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output logic      [31:0]           prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    // fifo store read side
    output logic      [TXFR_PTR_W-1:0] fifo_rd_addr_o,
    input  wire logic [31:0]           fifo_rd_data_i,
    input  wire logic [TXFR_PTR_W-1:0] fifo_wr_ptr_i,
    output logic      [TXFR_PTR_W-1:0] fifo_free_ptr_o,
    // offload engine report
    input  wire logic                  lso_hdr_vld_i,
    input  wire logic [9:0]            lso_hdr_size_i,
    // mac frame data
    output logic                       mac_valid_o,
    input  wire logic                  mac_ready_i,
    output logic      [31:0]           mac_data_o,
    output logic      [3:0]            mac_be_o,
    output logic                       mac_last_o,
    // mac sideband
    output logic                       mac_fcs_pad_o,
    output logic                       mac_ip_csum_o,
    output logic                       mac_l4_csum_o,
    output logic                       mac_icmp_csum_o,
    output logic                       mac_igmp_csum_o,
    // mac buffer requests
    input  wire logic                  frame_rewind_request_i,
    input  wire logic                  frame_release_request_i,
    // host facing status
    output logic                       transmit_error_flag_o,
    output logic                       bulk_out_stall_o
);

    // ========================================================
    // helpers
    function automatic logic [TXFR_NW_W-1:0] nwords(input logic [19:0] len);
        logic [20:0] s;
        s = {1'b0, len} + 21'h000003;
        return s[19:2];
    endfunction

    function automatic logic [3:0] last_be(input logic [1:0] lsb);
        logic [3:0] be;
        be = 4'hf;
        case (lsb)
            2'h1:    be = 4'h1;
            2'h2:    be = 4'h3;
            2'h3:    be = 4'h7;
            default: be = 4'hf;
        endcase
        return be;
    endfunction

    // first byte on the wire sits in bits 7:0
    function automatic logic [31:0] tag_word(input logic [15:0] ty, input logic [15:0] tag);
        return {tag[7:0], tag[15:8], ty[7:0], ty[15:8]};
    endfunction

    // ========================================================
    // state
    typedef struct packed {
        txfr_st_t              st;
        logic [TXFR_PTR_W-1:0] rd_ptr;
        logic [TXFR_PTR_W-1:0] start_ptr;
        logic [31:0]           cmd_a;
        logic [31:0]           cmd_b;
        logic [TXFR_NW_W-1:0]  widx;
        logic                  tag_done;
        logic                  out_v;
        logic [31:0]           out_d;
        logic [3:0]            out_be;
        logic                  out_last;
        logic                  err;
        logic                  stall;
        logic                  stall_dis;
        logic                  alt_en;
        logic [15:0]           alt_type;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
    } txfr_state_t;

    txfr_state_t s_q;
    txfr_state_t s_d;

    logic                  word_avail;
    logic                  out_free;
    logic                  large_send_offload_enable;
    logic [13:0]           max_segment_size;
    logic                  cmd_err;
    logic                  hdr_err;
    logic [TXFR_NW_W-1:0]  nw;
    logic [15:0]           tag_type;
    logic [31:0]           ins_word;
    logic                  is_tagged;
    logic                  at_tag_slot;
    logic                  is_last;
    logic                  wr_go;
    logic [31:0]           rd_val;
    logic                  rd_hit;

    always_comb
    begin
        word_avail  = s_q.rd_ptr != fifo_wr_ptr_i;
        out_free    = !s_q.out_v || mac_ready_i;
        large_send_offload_enable         = s_q.cmd_a[TXFR_A_LSO];
        max_segment_size         = fifo_rd_data_i[29:16];
        nw          = nwords(s_q.cmd_a[19:0]);
        // checks run while the second command word is on the fifo port
        cmd_err     = (large_send_offload_enable ? (max_segment_size < TXFR_MSS_MIN) : (max_segment_size != 14'h0000))
                    | (!large_send_offload_enable && s_q.cmd_a[19:16] != 4'h0)
                    | (!large_send_offload_enable && s_q.cmd_a[15:0] > TXFR_LEN_LO_MAX)
                    | (s_q.cmd_a[19:0] < TXFR_LEN_MIN_RAW
                       && !s_q.cmd_a[TXFR_A_FCSPAD])
                    | (s_q.cmd_a[TXFR_A_TAGREP] && !s_q.cmd_a[TXFR_A_TAGINS])
                    | (s_q.cmd_a[31:30] != 2'h0)
                    | (s_q.cmd_a[21:20] != 2'h0)
                    | (fifo_rd_data_i[31:30] != 2'h0);
        hdr_err     = large_send_offload_enable && lso_hdr_vld_i && lso_hdr_size_i > TXFR_HDR_MAX
                    && (s_q.st == TXFR_DATA || s_q.st == TXFR_DONE);
        tag_type    = s_q.alt_en ? s_q.alt_type : TXFR_TAG_TYPE_DEF;
        ins_word    = tag_word(tag_type, s_q.cmd_b[15:0]);
        // a frame counts as tagged by either type the block knows
        is_tagged   = tag_word(TXFR_TAG_TYPE_DEF, 16'h0000) ==
                          {16'h0000, fifo_rd_data_i[15:0]}
                    || tag_word(s_q.alt_type, 16'h0000) ==
                          {16'h0000, fifo_rd_data_i[15:0]};
        at_tag_slot = s_q.cmd_a[TXFR_A_TAGINS] && !s_q.tag_done
                    && s_q.widx == TXFR_TAG_WORD_IDX;
        is_last     = s_q.widx == nw - 18'h00001;
        wr_go       = psel_i && penable_i && s_q.pready && pwrite_i;
        rd_hit      = 1'b1;
        case (paddr_i)
            TXFR_OFS_ERRSTAT:  rd_val = {31'h0, s_q.err};
            TXFR_OFS_CONFIG:   rd_val = {31'h0, s_q.stall_dis};
            TXFR_OFS_ALT_TYPE: rd_val = {15'h0, s_q.alt_en, s_q.alt_type};
            TXFR_OFS_STATE:    rd_val = {4'h0, s_q.st, s_q.stall,
                                         s_q.start_ptr, s_q.rd_ptr};
            default:
            begin
                rd_val = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    // ========================================================
    // next state
    always_comb
    begin
        s_d = s_q;

        // apb: one wait cycle, read data lands as pready rises, a write lands at the edge after
        s_d.pready  = psel_i && penable_i && !s_q.pready;
        s_d.pslverr = 1'b0;
        if (psel_i && penable_i && !s_q.pready)
        begin
            s_d.prdata  = pwrite_i ? 32'h0 : rd_val;
            s_d.pslverr = !rd_hit;
        end
        if (wr_go && paddr_i == TXFR_OFS_CONFIG)
            s_d.stall_dis = pwdata_i[TXFR_CFG_STALLDIS];
        if (wr_go && paddr_i == TXFR_OFS_ALT_TYPE)
        begin
            s_d.alt_type = pwdata_i[15:0];
            s_d.alt_en   = pwdata_i[TXFR_ALT_EN];
        end
        // write one to clear; a new error in the same cycle still wins below
        if (wr_go && paddr_i == TXFR_OFS_ERRSTAT && pwdata_i[TXFR_STS_ERR])
            s_d.err = 1'b0;

        if (s_q.out_v && mac_ready_i)
            s_d.out_v = 1'b0;

        case (s_q.st)
            TXFR_IDLE:
            begin
                if (word_avail)
                begin
                    s_d.rd_ptr = s_q.rd_ptr + 12'h001;
                    s_d.st     = TXFR_CMDA;
                end
            end
            TXFR_CMDA:
            begin
                if (word_avail)
                begin
                    s_d.cmd_a  = fifo_rd_data_i;
                    s_d.rd_ptr = s_q.rd_ptr + 12'h001;
                    s_d.st     = TXFR_CMDB;
                end
            end
            TXFR_CMDB:
            begin
                if (word_avail)
                begin
                    s_d.cmd_b    = fifo_rd_data_i;
                    s_d.rd_ptr   = s_q.rd_ptr + 12'h001;
                    s_d.widx     = '0;
                    s_d.tag_done = 1'b0;
                    s_d.st       = cmd_err ? TXFR_HALT : TXFR_DATA;
                    if (cmd_err)
                        s_d.err = 1'b1;
                end
            end
            TXFR_DATA:
            begin
                if (out_free && word_avail)
                begin
                    s_d.out_v = 1'b1;
                    if (at_tag_slot)
                    begin
                        s_d.out_d    = ins_word;
                        s_d.out_be   = 4'hf;
                        s_d.out_last = 1'b0;
                        s_d.tag_done = 1'b1;
                        // replace consumes the old tag, insert keeps it behind
                        if (s_q.cmd_a[TXFR_A_TAGREP] && is_tagged)
                        begin
                            s_d.rd_ptr   = s_q.rd_ptr + 12'h001;
                            s_d.widx     = s_q.widx + 18'h00001;
                            s_d.out_last = is_last;
                            s_d.out_be   = is_last ? last_be(s_q.cmd_a[1:0]) : 4'hf;
                            s_d.st       = is_last ? TXFR_DONE : TXFR_DATA;
                        end
                    end
                    else
                    begin
                        s_d.out_d    = fifo_rd_data_i;
                        s_d.out_be   = is_last ? last_be(s_q.cmd_a[1:0]) : 4'hf;
                        s_d.out_last = is_last;
                        s_d.rd_ptr   = s_q.rd_ptr + 12'h001;
                        s_d.widx     = s_q.widx + 18'h00001;
                        if (is_last)
                            s_d.st = TXFR_DONE;
                    end
                end
            end
            TXFR_DONE:
            begin
                s_d.st = TXFR_DONE;
            end
            TXFR_HALT:
            begin
                // out of sync: stays here until device reset
                s_d.st = TXFR_HALT;
            end
            default:
            begin
                s_d.st = TXFR_IDLE;
            end
        endcase

        if (s_q.st == TXFR_DATA || s_q.st == TXFR_DONE)
        begin
            if (hdr_err)
            begin
                s_d.err   = 1'b1;
                s_d.out_v = 1'b0;
                s_d.st    = TXFR_HALT;
            end
            else if (frame_release_request_i)
            begin
                s_d.start_ptr = s_q.start_ptr + 12'(TXFR_HDR_WORDS)
                              + nw[TXFR_PTR_W-1:0];
                s_d.rd_ptr    = s_q.start_ptr + 12'(TXFR_HDR_WORDS)
                              + nw[TXFR_PTR_W-1:0];
                s_d.st        = TXFR_IDLE;
            end
            else if (frame_rewind_request_i)
            begin
                // header words were checked once; replay data only
                s_d.rd_ptr   = s_q.start_ptr + 12'(TXFR_HDR_WORDS);
                s_d.widx     = '0;
                s_d.tag_done = 1'b0;
                s_d.out_v    = 1'b0;
                s_d.st       = TXFR_DATA;
            end
        end

        s_d.stall = s_d.err && !s_q.stall_dis;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s_q           <= '0;
            s_q.st        <= TXFR_IDLE;
            s_q.stall_dis <= TXFR_RST_STALLDIS;
            s_q.alt_type  <= TXFR_RST_ALT_TYPE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ========================================================
    // outputs
    assign prdata_o              = s_q.prdata;
    assign pready_o              = s_q.pready;
    assign pslverr_o             = s_q.pslverr;
    assign fifo_rd_addr_o        = s_q.rd_ptr;
    assign fifo_free_ptr_o       = s_q.start_ptr;
    assign mac_valid_o           = s_q.out_v;
    assign mac_data_o            = s_q.out_d;
    assign mac_be_o              = s_q.out_be;
    assign mac_last_o            = s_q.out_last;
    // checksum engine behind the mac applies the ipv6 and tunnel limits
    assign mac_fcs_pad_o         = s_q.cmd_a[TXFR_A_FCSPAD];
    assign mac_ip_csum_o         = s_q.cmd_a[TXFR_A_IPCS];
    assign mac_l4_csum_o         = s_q.cmd_a[TXFR_A_L4CS];
    assign mac_icmp_csum_o       = s_q.cmd_a[TXFR_A_ICMP];
    assign mac_igmp_csum_o       = s_q.cmd_a[TXFR_A_IGMP];
    assign transmit_error_flag_o = s_q.err;
    assign bulk_out_stall_o      = s_q.stall;

endmodule

// ==== tb/txfr_readout_sva.sv ====
// port checker for the transmit frame readout block
// assumes one clock, asynchronous low reset, apb with one wait state
`timescale 1ns/1ps
module txfr_readout_sva
    import txfr_pkg::*;
(
    // clock and reset
    input wire logic                  mclk_i,
    input wire logic                  arst_n_i,
    // apb
    input wire logic                  psel_i,
    input wire logic                  penable_i,
    input wire logic                  pwrite_i,
    input wire logic [7:0]            paddr_i,
    input wire logic [31:0]           pwdata_i,
    input wire logic                  pready_o,
    input wire logic                  pslverr_o,
    // fifo and mac
    input wire logic [TXFR_PTR_W-1:0] fifo_free_ptr_o,
    input wire logic                  mac_valid_o,
    input wire logic                  mac_ready_i,
    input wire logic [31:0]           mac_data_o,
    input wire logic [3:0]            mac_be_o,
    input wire logic                  mac_last_o,
    input wire logic                  mac_fcs_pad_o,
    input wire logic                  mac_ip_csum_o,
    input wire logic                  mac_l4_csum_o,
    input wire logic                  mac_icmp_csum_o,
    input wire logic                  mac_igmp_csum_o,
    input wire logic                  frame_rewind_request_i,
    input wire logic                  frame_release_request_i,
    // status
    input wire logic                  transmit_error_flag_o,
    input wire logic                  bulk_out_stall_o
);
    // ========================================================
    // helpers
    logic       sent_q;
    logic [4:0] side_w;
    assign side_w = {mac_fcs_pad_o, mac_ip_csum_o, mac_l4_csum_o, mac_icmp_csum_o,
                     mac_igmp_csum_o};
    // requests only count once a whole frame went out
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            sent_q <= 1'b0;
        else if (frame_rewind_request_i || frame_release_request_i)
            sent_q <= 1'b0;
        else if (mac_valid_o && mac_ready_i && mac_last_o)
            sent_q <= 1'b1;
    end

    // ========================================================
    // properties
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    a_apb_one_wait: assert property (psel_i && $rose(penable_i) |=> pready_o)
        else $error("apb answer not after one wait");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    a_unmapped_err: assert property (pready_o |->
        pslverr_o == !(paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0c}))
        else $error("pslverr wrong for address");
    a_flag_sticky: assert property (transmit_error_flag_o && !(psel_i && penable_i &&
        pready_o && pwrite_i && paddr_i == 8'h00 && pwdata_i[0]) |=> transmit_error_flag_o)
        else $error("error flag dropped without clear");
    a_stall_needs_flag: assert property (!transmit_error_flag_o |-> !bulk_out_stall_o)
        else $error("stall without error flag");
    a_mac_hold: assert property (mac_valid_o && !mac_ready_i |=> mac_valid_o &&
        $stable(mac_data_o) && $stable(mac_be_o) && $stable(mac_last_o))
        else $error("mac word changed while stalled");
    a_full_be: assert property (mac_valid_o && !mac_last_o |-> mac_be_o == 4'hf)
        else $error("partial enables before last word");
    a_last_be: assert property (mac_valid_o && mac_last_o |->
        mac_be_o inside {4'h1, 4'h3, 4'h7, 4'hf})
        else $error("last word enables not contiguous");
    a_side_steady: assert property (mac_valid_o && $past(mac_valid_o) |-> $stable(side_w))
        else $error("sideband changed inside frame");
    a_rewind_replay: assert property (frame_rewind_request_i && !frame_release_request_i &&
        sent_q |-> !mac_valid_o ##[1:10] mac_valid_o)
        else $error("no replay after rewind");
    a_release_frees: assert property (frame_release_request_i && sent_q |->
        ##[1:4] $changed(fifo_free_ptr_o))
        else $error("release did not move free pointer");
    a_err_no_data: assert property ($rose(transmit_error_flag_o) && !mac_valid_o |=>
        !mac_valid_o [*4])
        else $error("data sent after command error");
endmodule

bind txfr_readout txfr_readout_sva u_sva (.*);

// ==== tb/txfr_mac_model.sv ====
// mac transmit partner: takes words, retries once on command, then releases
// assumes the readout holds each word until ready
`timescale 1ns/1ps
module txfr_mac_model (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    // frame stream
    input  wire logic        mac_valid_i,
    input  wire logic [31:0] mac_data_i,
    input  wire logic [3:0]  mac_be_i,
    input  wire logic        mac_last_i,
    output logic             mac_ready_o,
    // bench controls
    input  wire logic        slow_i,
    input  wire logic        retry_i,
    // buffer requests
    output logic             rewind_o,
    output logic             release_o
);
    logic [31:0] cap_d [0:1023];
    logic [3:0]  cap_be [0:1023];
    int          n = 0;
    logic        retried;
    // capture log survives reset so the bench can index it by a base
    always @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            mac_ready_o <= 1'b0;
            rewind_o <= 1'b0;
            release_o <= 1'b0;
            retried <= 1'b0;
        end
        else
        begin
            rewind_o <= 1'b0;
            release_o <= 1'b0;
            mac_ready_o <= slow_i ? !mac_ready_o : 1'b1;
            if (mac_valid_i && mac_ready_o)
            begin
                cap_d[n] <= mac_data_i;
                cap_be[n] <= mac_be_i;
                n <= n + 1;
                if (mac_last_i && retry_i && !retried)
                begin
                    rewind_o <= 1'b1;
                    retried <= 1'b1;
                end
                else if (mac_last_i)
                begin
                    release_o <= 1'b1;
                    retried <= 1'b0;
                end
            end
        end
    end
endmodule

// ==== tb/tb_txfr_readout.sv ====
// self-checking bench for the transmit frame readout
// assumes the mac partner model and a word store held here
`timescale 1ns/1ps
`define chk(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_txfr_readout
    import txfr_pkg::*;
;
    logic                  mclk_i = 1'b0, arst_n_i, psel_i = 1'b0, penable_i = 1'b0;
    logic                  pwrite_i = 1'b0, pready_o, pslverr_o, mac_valid_o, mac_ready_i;
    logic                  mac_last_o, lso_hdr_vld_i = 1'b0, er, slow = 1'b0, retry = 1'b0;
    logic                  mac_fcs_pad_o, mac_ip_csum_o, mac_l4_csum_o, mac_icmp_csum_o;
    logic                  mac_igmp_csum_o, frame_rewind_request_i, frame_release_request_i;
    logic                  transmit_error_flag_o, bulk_out_stall_o;
    logic [7:0]            paddr_i = 8'h00;
    logic [9:0]            lso_hdr_size_i = 10'h000;
    logic [3:0]            mac_be_o;
    logic [15:0]           tt = TXFR_TAG_TYPE_DEF;
    logic [31:0]           pwdata_i = 32'h0, prdata_o, fifo_rd_data_i, mac_data_o, rd;
    logic [31:0]           mem [0:4095];
    logic [TXFR_PTR_W-1:0] fifo_rd_addr_o, fifo_free_ptr_o, fifo_wr_ptr_i = '0, wp = '0;
    int                    bad_count = 0, cmp_count = 0, k;

    assign fifo_rd_data_i = mem[fifo_rd_addr_o];
    initial forever #2 mclk_i = ~mclk_i;

    txfr_readout DUT (.*);
    txfr_mac_model mac (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .mac_valid_i(mac_valid_o),
        .mac_data_i(mac_data_o), .mac_be_i(mac_be_o), .mac_last_i(mac_last_o),
        .mac_ready_o(mac_ready_i), .slow_i(slow), .retry_i(retry),
        .rewind_o(frame_rewind_request_i), .release_o(frame_release_request_i)
    );

    // ========================================================
    // tasks
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        @(posedge mclk_i);
        while (pready_o !== 1'b1)
            @(posedge mclk_i);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge mclk_i);
        arst_n_i <= 1'b0;
        wp = '0;
        fifo_wr_ptr_i <= '0;
        repeat (6) @(posedge mclk_i);
        arst_n_i <= 1'b1;
    endtask

    // byte i of the frame is i; word 3 of a tagged frame holds a tag
    function automatic logic [31:0] word(input int i, input bit tg);
        logic [7:0] b;
        b = 8'(4 * i);
        if (tg && i == 3)
            return {8'h5a, 8'h3c, tt[7:0], tt[15:8]};
        return {b + 8'h3, b + 8'h2, b + 8'h1, b};
    endfunction

    task automatic load(input logic [31:0] a, input logic [31:0] b, input bit tg);
        int n;
        n = (int'(a[15:0]) + 3) / 4;
        mem[wp] = {12'h000, a[19:0]};
        mem[wp + 12'h1] = a;
        mem[wp + 12'h2] = b;
        for (int i = 0; i < n; i++)
            mem[wp + 12'(3 + i)] = word(i, tg);
        wp = wp + 12'(3 + n);
        fifo_wr_ptr_i <= wp;
    endtask

    task automatic frame(input logic [31:0] a, input logic [31:0] b, input bit tg, input bit rt);
        logic [31:0] q[$];
        int          base;
        retry <= rt;
        base = mac.n;
        load(a, b, tg);
        for (int i = 0; i < (int'(a[15:0]) + 3) / 4; i++)
        begin
            if (a[24] && i == 3)
                q.push_back({b[7:0], b[15:8], tt[7:0], tt[15:8]});
            if (!(a[24] && a[23] && tg && i == 3))
                q.push_back(word(i, tg));
        end
        for (k = 0; k < 200 && mac_valid_o !== 1'b1; k++)
            @(posedge mclk_i);
        `chk({mac_fcs_pad_o, mac_ip_csum_o, mac_l4_csum_o, mac_icmp_csum_o, mac_igmp_csum_o}, {a[22], a[26], a[25], a[28], a[29]})
        for (k = 0; k < 200 && fifo_free_ptr_o !== wp; k++)
            @(posedge mclk_i);
        `chk(fifo_free_ptr_o, wp)
        `chk(mac.n, base + q.size() * (rt + 1))
        for (int i = 0; i < q.size() * (rt + 1); i++)
            `chk(mac.cap_d[base + i], q[i % q.size()])
        `chk(mac.cap_be[base + q.size() - 1], 4'((1 << (a[1:0] == 2'd0 ? 4 : a[1:0])) - 1))
    endtask

    task automatic err_case(input logic [31:0] a, input logic [31:0] b, input bit dis);
        int base;
        do_reset();
        if (dis)
            apb(1'b1, TXFR_OFS_CONFIG, 32'h1);
        base = mac.n;
        load(a, b, 1'b0);
        repeat (12) @(posedge mclk_i);
        `chk(transmit_error_flag_o, 1'b1)
        `chk(bulk_out_stall_o, !dis)
        `chk(mac.n, base)
    endtask

    // ========================================================
    // tests
    initial
    begin
        #(40000 * 4);
        bad_count++;
        test_done();
    end

    initial
    begin
        arst_n_i = 1'b0;
        do_reset();
        apb(1'b0, TXFR_OFS_CONFIG, 32'h0);
        `chk(rd, 32'h0)
        apb(1'b0, TXFR_OFS_ALT_TYPE, 32'h0);
        `chk(rd, 32'h0000_8100)
        apb(1'b1, 8'h10, 32'hffff_ffff);
        `chk(er, 1'b1)
        apb(1'b0, 8'h10, 32'h0);
        `chk({er, rd}, {1'b1, 32'h0})
        frame(32'h3640_0021, 32'h0, 1'b0, 1'b1);
        frame(32'h0000_0020, 32'h0, 1'b0, 1'b0);
        slow <= 1'b1;
        frame(32'h0140_0028, 32'h0000_a123, 1'b0, 1'b0);
        frame(32'h0140_0026, 32'h0000_6fed, 1'b1, 1'b0);
        frame(32'h01c0_0022, 32'h0000_0001, 1'b0, 1'b0);
        apb(1'b1, TXFR_OFS_ALT_TYPE, 32'h0001_88a8);
        tt = 16'h88a8;
        frame(32'h01c0_0025, 32'h0000_b00c, 1'b1, 1'b0);
        slow <= 1'b0;
        // offload header limit, boundary first
        do_reset();
        load(32'h0840_0040, 32'h0008_0000, 1'b0);
        for (k = 0; k < 200 && mac_valid_o !== 1'b1; k++)
            @(posedge mclk_i);
        lso_hdr_size_i <= 10'h100;
        lso_hdr_vld_i <= 1'b1;
        @(posedge mclk_i);
        lso_hdr_vld_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        `chk(transmit_error_flag_o, 1'b0)
        lso_hdr_size_i <= 10'h101;
        lso_hdr_vld_i <= 1'b1;
        @(posedge mclk_i);
        lso_hdr_vld_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        `chk(transmit_error_flag_o, 1'b1)
        err_case(32'h0840_0040, 32'h0004_0000, 1'b0);
        err_case(32'h0040_0040, 32'h0008_0000, 1'b0);
        err_case(32'h0041_0040, 32'h0, 1'b0);
        err_case(32'h0040_2ff8, 32'h0, 1'b0);
        err_case(32'h0000_001f, 32'h0, 1'b0);
        err_case(32'h00c0_0040, 32'h0, 1'b0);
        err_case(32'h4040_0040, 32'h0, 1'b0);
        err_case(32'h0050_0040, 32'h0, 1'b0);
        err_case(32'h0040_0040, 32'h4000_0000, 1'b1);
        apb(1'b0, TXFR_OFS_ERRSTAT, 32'h0);
        `chk(rd[0], 1'b1)
        apb(1'b1, TXFR_OFS_ERRSTAT, 32'h1);
        apb(1'b0, TXFR_OFS_ERRSTAT, 32'h0);
        `chk(rd[0], 1'b0)
        test_done();
    end
endmodule
